// file: design/ddr3_burst_fifo.sv
`default_nettype none
module ddr3_burst_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] rd_ptr;
        logic [AW-1:0] wr_ptr;
        logic [AW:0]   count;
    } fifo_state_t;

    fifo_state_t      st;
    fifo_state_t      next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_out  = (st.count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid_out = (st.count != '0);
    assign out_data_out  = mem[st.rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = st.wr_ptr + AW'(1);
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            next_st.count = st.count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_st.count = st.count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[st.wr_ptr] <= in_data_in;
        end
    end
endmodule // ddr3_burst_fifo
`default_nettype wire

// file: design/ddr3_cmd_pkg.sv
`default_nettype none
package ddr3_cmd_pkg;
    localparam int BANK_COUNT   = 8;
    localparam int BANK_BITS    = 3;
    localparam int ADDR_BITS    = 13;
    localparam int DQ_BITS      = 16;
    localparam int DM_BITS      = 2;
    localparam int LANE_BITS    = 8;
    localparam int COL_BITS     = 10;
    localparam int PREFETCH     = 8;
    localparam int CORE_BITS    = PREFETCH * DQ_BITS;
    localparam int CORE_CLOCKS  = 4;
    localparam int FIFO_DEPTH   = 32;
    localparam int BURST_LONG   = 8;
    localparam int BURST_CHOP   = 4;
    localparam int AP_BIT       = 10;
    localparam int BC_BIT       = 12;
    localparam int COL_HI_BIT   = 11;
    localparam int BEAT_BITS    = 4;
    localparam logic [BEAT_BITS-1:0] BEATS_LONG = 4'h8;
    localparam logic [BEAT_BITS-1:0] BEATS_CHOP = 4'h4;
    localparam logic [BANK_COUNT-1:0] ALL_BANKS_IDLE = 8'h00;
    localparam logic [ADDR_BITS-1:0] ADDR_RESET = 13'h0000;

    typedef enum logic [3:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_PRECHARGE,
        CMD_READ,
        CMD_WRITE,
        CMD_MODE_SET,
        CMD_REFRESH,
        CMD_ZQ_CAL,
        CMD_ILLEGAL
    } cmd_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_DOWN,
        PWR_SELF_REFRESH
    } pwr_t;
endpackage
`default_nettype wire

// file: design/ddr3_core_gather.sv
`default_nettype none
// packs eight beats into one core-wide word for the array side
module ddr3_core_gather
    import ddr3_cmd_pkg::*;
(
    input  wire logic                 clock_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 beat_valid_in,
    output logic                      beat_ready_out,
    input  wire logic [DQ_BITS-1:0]   beat_data_in,
    input  wire logic [DM_BITS-1:0]   beat_mask_in,
    output logic                      core_valid_out,
    output logic [CORE_BITS-1:0]      core_data_out,
    output logic [PREFETCH*DM_BITS-1:0] core_mask_out
);
    typedef struct packed {
        logic [2:0]                   slot;
        logic                         full;
        logic [CORE_BITS-1:0]         data;
        logic [PREFETCH*DM_BITS-1:0]  mask;
    } gather_state_t;

    gather_state_t st;
    gather_state_t next_st;

    assign beat_ready_out = 1'b1;
    assign core_valid_out = st.full;
    assign core_data_out  = st.data;
    assign core_mask_out  = st.mask;

    always_comb begin
        next_st      = st;
        next_st.full = 1'b0;
        if (beat_valid_in) begin
            next_st.data[st.slot*DQ_BITS +: DQ_BITS] = beat_data_in;
            next_st.mask[st.slot*DM_BITS +: DM_BITS] = beat_mask_in;
            next_st.slot = st.slot + 3'h1;
            next_st.full = (st.slot == 3'h7);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // ddr3_core_gather
`default_nettype wire

// file: design/ddr3_sdram_command_decoder.sv
`default_nettype none
module ddr3_sdram_command_decoder
    import ddr3_cmd_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input  wire logic                       clock_in,
    input  wire logic                       reset_n_in,
    input  wire logic                       cke_in,
    input  wire logic                       cs_n_in,
    input  wire logic                       ras_n_in,
    input  wire logic                       cas_n_in,
    input  wire logic                       we_n_in,
    input  wire logic [BANK_BITS-1:0]       bank_in,
    input  wire logic [ADDR_BITS-1:0]       addr_in,
    input  wire logic                       otf_enable_in,
    input  wire logic                       fixed_chop_in,
    input  wire logic [DQ_BITS-1:0]         wdata_rise_in,
    input  wire logic [DQ_BITS-1:0]         wdata_fall_in,
    input  wire logic [DM_BITS-1:0]         mask_rise_in,
    input  wire logic [DM_BITS-1:0]         mask_fall_in,
    input  wire logic [CORE_BITS-1:0]       core_rdata_in,
    output logic [DQ_BITS-1:0]              rdata_rise_out,
    output logic [DQ_BITS-1:0]              rdata_fall_out,
    output logic                            rdata_valid_out,
    output logic                            core_wvalid_out,
    output logic [CORE_BITS-1:0]            core_wdata_out,
    output logic [PREFETCH*DM_BITS-1:0]     core_wmask_out,
    output logic                            wdata_ready_out,
    output logic [3:0]                      cmd_out,
    output logic [BANK_BITS-1:0]            cmd_bank_out,
    output logic [ADDR_BITS-1:0]            row_out,
    output logic [COL_BITS-1:0]             column_out,
    output logic                            auto_precharge_out,
    output logic                            chop_out,
    output logic                            zq_long_out,
    output logic [ADDR_BITS-1:0]            mode_opcode_out,
    output logic [BANK_BITS-1:0]            mode_select_out,
    output logic [BANK_COUNT-1:0]           bank_active_out,
    output logic [1:0]                      power_state_out,
    output logic                            self_refresh_out
);
    typedef struct packed {
        logic                         cke_prev;
        pwr_t                         pwr;
        logic [BANK_COUNT-1:0]        active;
        logic [BANK_COUNT*ADDR_BITS-1:0] rows;
        cmd_t                         cmd;
        logic [BANK_BITS-1:0]         bank;
        logic [ADDR_BITS-1:0]         row;
        logic [COL_BITS-1:0]          col;
        logic                         ap;
        logic                         chop;
        logic                         zq_long;
        logic [ADDR_BITS-1:0]         opcode;
        logic [BANK_BITS-1:0]         mr_sel;
        logic                         rd_busy;
        logic                         wr_busy;
        logic [BEAT_BITS-1:0]         beats_left;
        logic                         burst_chop;
        logic                         burst_ap;
        logic [BANK_BITS-1:0]         burst_bank;
        logic [2:0]                   beat_idx;
        logic [DQ_BITS-1:0]           rd_rise;
        logic [DQ_BITS-1:0]           rd_fall;
        logic                         rd_valid;
    } dec_state_t;

    dec_state_t st;
    dec_state_t next_st;

    cmd_t                 decoded;
    logic                 all_idle;
    logic                 nop_or_des;
    logic                 burst_chop_now;
    logic                 fifo_in_valid;
    logic                 fifo_in_ready;
    logic [2*(DQ_BITS+DM_BITS)-1:0] fifo_in_data;
    logic                 fifo_out_valid;
    logic                 fifo_out_ready;
    logic [2*(DQ_BITS+DM_BITS)-1:0] fifo_out_data;
    logic                 beat_sel;
    logic                 beat_valid;
    logic [DQ_BITS-1:0]   beat_data;
    logic [DM_BITS-1:0]   beat_mask;
    logic                 half_q;

    // raw command decode from the strobes
    always_comb begin
        if (cs_n_in) begin
            decoded = CMD_DESELECT;
        end else begin
            unique case ({ras_n_in, cas_n_in, we_n_in})
                3'b111: decoded = CMD_NOP;
                3'b011: decoded = CMD_ACTIVATE;
                3'b010: decoded = CMD_PRECHARGE;
                3'b101: decoded = CMD_READ;
                3'b100: decoded = CMD_WRITE;
                3'b000: decoded = CMD_MODE_SET;
                3'b001: decoded = CMD_REFRESH;
                3'b110: decoded = CMD_ZQ_CAL;
                default: decoded = CMD_ILLEGAL;
            endcase
        end
    end

    assign all_idle   = (st.active == ALL_BANKS_IDLE);
    assign nop_or_des = (decoded == CMD_DESELECT) || (decoded == CMD_NOP);
    // on-the-fly A12 low chops; otherwise the fixed setting decides
    assign burst_chop_now = otf_enable_in ? !addr_in[BC_BIT] : fixed_chop_in;

    // write beats: one rise and one fall word per clock into the fifo
    assign fifo_in_valid = st.wr_busy;
    assign fifo_in_data  = {mask_fall_in, wdata_fall_in, mask_rise_in, wdata_rise_in};
    assign wdata_ready_out = fifo_in_ready;

    // fifo drains one beat at a time; the first half stalls the fifo
    assign beat_sel       = half_q;
    assign fifo_out_ready = half_q;
    assign beat_valid     = fifo_out_valid;
    assign beat_data = beat_sel ? fifo_out_data[DQ_BITS+DM_BITS +: DQ_BITS]
                                : fifo_out_data[0 +: DQ_BITS];
    assign beat_mask = beat_sel ? fifo_out_data[2*DQ_BITS+DM_BITS +: DM_BITS]
                                : fifo_out_data[DQ_BITS +: DM_BITS];

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            half_q <= 1'b0;
        end else if (fifo_out_valid) begin
            half_q <= !half_q;
        end
    end

    ddr3_burst_fifo #(
        .WIDTH (2*(DQ_BITS+DM_BITS)),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .clock_in      (clock_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    // eight beats form one core word; mask bits travel with it
    ddr3_core_gather u_gather (
        .clock_in       (clock_in),
        .reset_n_in     (reset_n_in),
        .beat_valid_in  (beat_valid),
        .beat_ready_out (),
        .beat_data_in   (beat_data),
        .beat_mask_in   (beat_mask),
        .core_valid_out (core_wvalid_out),
        .core_data_out  (core_wdata_out),
        .core_mask_out  (core_wmask_out)
    );

    always_comb begin
        next_st          = st;
        next_st.cke_prev = cke_in;
        next_st.cmd      = CMD_NOP;
        next_st.rd_valid = 1'b0;

        // previous and present clock enable samples
        if (st.pwr != PWR_ACTIVE) begin
            if (!st.cke_prev && cke_in && nop_or_des) begin
                next_st.pwr = PWR_ACTIVE;
            end
        end else if (st.cke_prev && !cke_in) begin
            if (decoded == CMD_REFRESH && all_idle) begin
                next_st.pwr = PWR_SELF_REFRESH;
            end else if (nop_or_des) begin
                next_st.pwr = PWR_DOWN;
            end
        end else if (st.cke_prev && cke_in) begin
            unique case (decoded)
                CMD_ACTIVATE: begin
                    if (!st.active[bank_in]) begin
                        next_st.active[bank_in] = 1'b1;
                        next_st.rows[bank_in*ADDR_BITS +: ADDR_BITS] = addr_in;
                        next_st.cmd  = CMD_ACTIVATE;
                        next_st.bank = bank_in;
                        next_st.row  = addr_in;
                    end
                end
                CMD_PRECHARGE: begin
                    if (addr_in[AP_BIT]) begin
                        next_st.active = ALL_BANKS_IDLE;
                    end else begin
                        next_st.active[bank_in] = 1'b0;
                    end
                    next_st.cmd  = CMD_PRECHARGE;
                    next_st.bank = bank_in;
                    next_st.ap   = addr_in[AP_BIT];
                end
                CMD_READ, CMD_WRITE: begin
                    if (st.active[bank_in]) begin
                        next_st.cmd        = decoded;
                        next_st.bank       = bank_in;
                        next_st.row        = st.rows[bank_in*ADDR_BITS +: ADDR_BITS];
                        next_st.col        = addr_in[COL_BITS-1:0];
                        next_st.ap         = addr_in[AP_BIT];
                        next_st.chop       = burst_chop_now;
                        next_st.rd_busy    = (decoded == CMD_READ);
                        next_st.wr_busy    = (decoded == CMD_WRITE);
                        // two beats per clock, so halve the beat count
                        next_st.beats_left = (burst_chop_now ? BEATS_CHOP : BEATS_LONG) >> 1;
                        next_st.burst_chop = burst_chop_now;
                        next_st.burst_ap   = addr_in[AP_BIT];
                        next_st.burst_bank = bank_in;
                        next_st.beat_idx   = addr_in[2:0];
                    end
                end
                CMD_MODE_SET: begin
                    if (all_idle) begin
                        next_st.cmd    = CMD_MODE_SET;
                        next_st.mr_sel = bank_in;
                        next_st.opcode = addr_in;
                    end
                end
                CMD_REFRESH: begin
                    if (all_idle) begin
                        next_st.cmd = CMD_REFRESH;
                    end
                end
                CMD_ZQ_CAL: begin
                    if (all_idle) begin
                        next_st.cmd     = CMD_ZQ_CAL;
                        next_st.zq_long = addr_in[AP_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // burst in progress: reads take two beats per clock out of the core word; writes only count down
        if (st.rd_busy || st.wr_busy) begin
            if (st.rd_busy) begin
                next_st.rd_rise  = core_rdata_in[st.beat_idx*DQ_BITS +: DQ_BITS];
                next_st.rd_fall  = core_rdata_in[3'(st.beat_idx+3'h1)*DQ_BITS +: DQ_BITS];
                next_st.rd_valid = 1'b1;
            end
            next_st.beat_idx   = st.beat_idx + 3'h2;
            next_st.beats_left = st.beats_left - 4'h1;
            if (st.beats_left == 4'h1) begin
                next_st.rd_busy = 1'b0;
                next_st.wr_busy = 1'b0;
                if (st.burst_ap) begin
                    next_st.active[st.burst_bank] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_rise_out     = st.rd_rise;
    assign rdata_fall_out     = st.rd_fall;
    assign rdata_valid_out    = st.rd_valid;
    assign cmd_out            = st.cmd;
    assign cmd_bank_out       = st.bank;
    assign row_out            = st.row;
    assign column_out         = st.col;
    assign auto_precharge_out = st.ap;
    assign chop_out           = st.chop;
    assign zq_long_out        = st.zq_long;
    assign mode_opcode_out    = st.opcode;
    assign mode_select_out    = st.mr_sel;
    assign bank_active_out    = st.active;
    assign power_state_out    = st.pwr;
    assign self_refresh_out   = (st.pwr == PWR_SELF_REFRESH);
endmodule // ddr3_sdram_command_decoder
`default_nettype wire

// file: dv/ddr3_cmd_assertions.sv
`default_nettype none
module ddr3_cmd_checker (
    input wire logic        clock_in,
    input wire logic        reset_n_in,
    input wire logic        cke_in,
    input wire logic        cs_n_in,
    input wire logic        ras_n_in,
    input wire logic        cas_n_in,
    input wire logic        we_n_in,
    input wire logic [2:0]  bank_in,
    input wire logic [12:0] addr_in,
    input wire logic        otf_enable_in,
    input wire logic        fixed_chop_in,
    input wire logic [3:0]  cmd_out,
    input wire logic [2:0]  cmd_bank_out,
    input wire logic [12:0] row_out,
    input wire logic [9:0]  column_out,
    input wire logic        auto_precharge_out,
    input wire logic        chop_out,
    input wire logic        rdata_valid_out,
    input wire logic [7:0]  bank_active_out,
    input wire logic [1:0]  power_state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        pcke;
    logic        prst;
    logic        potf;
    logic        pfix;
    logic [2:0]  pb;
    logic [12:0] pa;
    logic [2:0]  op;
    logic        ok;
    logic        nop;
    always_ff @(posedge clock_in) begin
        pcke <= cke_in;
        prst <= reset_n_in;
        potf <= otf_enable_in;
        pfix <= fixed_chop_in;
        pb <= bank_in;
        pa <= addr_in;
    end
    assign op = {ras_n_in, cas_n_in, we_n_in};
    assign nop = cs_n_in || op == 3'h7;
    assign ok = prst && pcke && cke_in && !cs_n_in && power_state_out == 2'h0;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    property p_desel;
        cs_n_in |=> cmd_out == 4'h1;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect not nop");
    property p_act;
        ok && op == 3'h3 && !bank_active_out[bank_in] |=> cmd_out == 4'h2
            && cmd_bank_out == pb && row_out == pa && bank_active_out[pb];
    endproperty
    a_act: assert property (p_act) else $error("activate wrong");
    property p_rd;
        ok && op == 3'h5 && bank_active_out[bank_in] |=> cmd_out == 4'h4
            && column_out == pa[9:0] && auto_precharge_out == pa[10];
    endproperty
    a_rd: assert property (p_rd) else $error("read wrong");
    property p_wr;
        ok && op == 3'h4 && bank_active_out[bank_in] |=> cmd_out == 4'h5;
    endproperty
    a_wr: assert property (p_wr) else $error("write wrong");
    property p_chop;
        ok && op[2:1] == 2'h2 && bank_active_out[bank_in]
            |=> chop_out == (potf ? !pa[12] : pfix);
    endproperty
    a_chop: assert property (p_chop) else $error("chop wrong");
    property p_burst;
        ok && op == 3'h5 && bank_active_out[bank_in] |=> ##1 rdata_valid_out[*2]
            ##1 (chop_out || rdata_valid_out) ##1 (chop_out || rdata_valid_out);
    endproperty
    a_burst: assert property (p_burst) else $error("burst short");
    property p_pre;
        ok && op == 3'h2 |=> cmd_out == 4'h3
            && (pa[10] ? bank_active_out == 8'h00 : !bank_active_out[pb]);
    endproperty
    a_pre: assert property (p_pre) else $error("precharge wrong");
    property p_ref;
        ok && op == 3'h1 && bank_active_out == 8'h00 |=> cmd_out == 4'h7;
    endproperty
    a_ref: assert property (p_ref) else $error("refresh wrong");
    property p_zq;
        ok && op == 3'h6 && bank_active_out == 8'h00 |=> cmd_out == 4'h8;
    endproperty
    a_zq: assert property (p_zq) else $error("zq wrong");
    property p_pd_in;
        prst && pcke && !cke_in && nop && power_state_out == 2'h0
            |=> power_state_out == 2'h1;
    endproperty
    a_pd_in: assert property (p_pd_in) else $error("no power-down");
    property p_pd_out;
        power_state_out != 2'h0 && !pcke && cke_in && nop |=> power_state_out == 2'h0;
    endproperty
    a_pd_out: assert property (p_pd_out) else $error("no exit");
    c_read: cover property (ok && op == 3'h5 && bank_active_out[bank_in]);
    c_down: cover property (power_state_out == 2'h1);
    c_self: cover property (power_state_out == 2'h2);
endmodule // ddr3_cmd_checker
bind ddr3_sdram_command_decoder ddr3_cmd_checker i_chk (.clock_in, .reset_n_in,
    .cke_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .bank_in, .addr_in,
    .otf_enable_in, .fixed_chop_in, .cmd_out, .cmd_bank_out, .row_out,
    .column_out, .auto_precharge_out, .chop_out, .rdata_valid_out,
    .bank_active_out, .power_state_out);
`default_nettype wire

// file: dv/ddr3_ctrl_model.sv
`default_nettype none
module ddr3_ctrl_model (
    input  wire logic        clock_in,
    output logic             cke_out,
    output logic             cs_n_out,
    output logic             ras_n_out,
    output logic             cas_n_out,
    output logic             we_n_out,
    output logic [2:0]       bank_out,
    output logic [12:0]      addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // cke stays low until the bench raises it after reset
    initial begin
        cke_out = 1'b0;
        cs_n_out = 1'b1;
        {ras_n_out, cas_n_out, we_n_out} = 3'h7;
        bank_out = 3'h0;
        addr_out = 13'h0000;
    end
    // callers need not open a row first; t_init reads and writes a closed bank
    task automatic send(input logic [2:0] c, input logic [2:0] b,
                        input logic [12:0] a, input logic k);
        @(posedge clock_in);
        #1;
        cke_out = k;
        cs_n_out = 1'b0;
        {ras_n_out, cas_n_out, we_n_out} = c;
        bank_out = b;
        addr_out = a;
    endtask
    // deselect; command, bank and address pins show the inverse of their last value
    task automatic desel(input logic k);
        @(posedge clock_in);
        #1;
        cke_out = k;
        cs_n_out = 1'b1;
        {ras_n_out, cas_n_out, we_n_out} = ~{ras_n_out, cas_n_out, we_n_out};
        bank_out = ~bank_out;
        addr_out = ~addr_out;
    endtask
endmodule // ddr3_ctrl_model
`default_nettype wire

// file: dv/ddr3_sdram_command_decoder_tb.sv
`default_nettype none
module ddr3_sdram_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset_n;
    logic cke, cs_n, ras_n, cas_n, we_n, otf, fix, ap, chop, zq, rv, cwv, rdy, sr;
    logic [2:0] bank, cbank, msel;
    logic [12:0] addr, row, mop;
    logic [15:0] rr, rf, wdr, wdf;
    logic [9:0] col;
    logic [3:0] cmd;
    logic [7:0] act;
    logic [1:0] pwr, mkr, mkf;
    logic [15:0] cwm;
    logic [127:0] crd, cwd;
    int fail_count = 0;
    int checks_done = 0;
    ddr3_ctrl_model i_ctrl (.clock_in(clk), .cke_out(cke), .cs_n_out(cs_n),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .bank_out(bank),
        .addr_out(addr));
    ddr3_sdram_command_decoder #(.FIFO_WORDS(32)) i_dut (.clock_in(clk),
        .reset_n_in(reset_n), .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n),
        .cas_n_in(cas_n), .we_n_in(we_n), .bank_in(bank), .addr_in(addr),
        .otf_enable_in(otf), .fixed_chop_in(fix), .wdata_rise_in(wdr),
        .wdata_fall_in(wdf), .mask_rise_in(mkr), .mask_fall_in(mkf),
        .core_rdata_in(crd), .rdata_rise_out(rr), .rdata_fall_out(rf),
        .rdata_valid_out(rv), .core_wvalid_out(cwv), .core_wdata_out(cwd),
        .core_wmask_out(cwm), .wdata_ready_out(rdy), .cmd_out(cmd),
        .cmd_bank_out(cbank), .row_out(row), .column_out(col),
        .auto_precharge_out(ap), .chop_out(chop), .zq_long_out(zq),
        .mode_opcode_out(mop), .mode_select_out(msel), .bank_active_out(act),
        .power_state_out(pwr), .self_refresh_out(sr));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [15:0] bt(input int k);
        return 16'(k % 8 + 1) * 16'h1111;
    endfunction
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [127:0] s, input logic [127:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic issue(input logic [2:0] c, input logic [2:0] b,
                         input logic [12:0] a, input logic [3:0] e);
        i_ctrl.send(c, b, a, 1'b1);
        i_ctrl.desel(1'b1);
        chk("cmd", cmd, e);
    endtask
    task automatic t_init;
        i_ctrl.desel(1'b1);
        i_ctrl.desel(1'b1);
        chk("nop", cmd, 4'h1);
        chk("banks", act, 8'h00);
        issue(3'h0, 3'h2, 13'h0a5a, 4'h6);
        chk("mode sel", msel, 3'h2);
        chk("opcode", mop, 13'h0a5a);
        issue(3'h6, 3'h0, 13'h0400, 4'h8);
        chk("zq long", zq, 1'b1);
        issue(3'h6, 3'h0, 13'h0000, 4'h8);
        chk("zq long", zq, 1'b0);
        issue(3'h5, 3'h2, 13'h0000, 4'h1);
        issue(3'h4, 3'h2, 13'h0000, 4'h1);
        $display("test init done");
    endtask
    task automatic t_read;
        issue(3'h3, 3'h5, 13'h1abc, 4'h2);
        chk("row", row, 13'h1abc);
        chk("bank", cbank, 3'h5);
        chk("open", act, 8'h20);
        issue(3'h5, 3'h5, 13'h0003, 4'h4);
        tick;
        for (int p = 0; p < 4; p++) begin
            chk("valid", rv, 1'b1);
            chk("rise", rr, bt(3 + 2 * p));
            chk("fall", rf, bt(4 + 2 * p));
            tick;
        end
        chk("valid", rv, 1'b0);
        $display("test read done");
    endtask
    task automatic t_chop;
        int n;
        logic ch;
        logic [2:0] cs [4];
        cs = '{3'h4, 3'h7, 3'h3, 3'h1};
        for (int i = 0; i < 4; i++) begin
            {otf, fix} = cs[i][2:1];
            ch = cs[i][2] ? !cs[i][0] : cs[i][1];
            issue(3'h5, 3'h5, {cs[i][0], 1'b0, 1'(i == 3), 10'h000}, 4'h4);
            chk("chop", chop, ch);
            chk("auto", ap, 1'(i == 3));
            n = 0;
            tick;
            while (rv === 1'b1 && n < 10) begin
                n++;
                tick;
            end
            chk("pairs", n, ch ? 2 : 4);
        end
        repeat (4) tick;
        chk("closed", act, 8'h00);
        $display("test chop done");
    endtask
    task automatic t_write;
        int n;
        issue(3'h3, 3'h1, 13'h0011, 4'h2);
        issue(3'h4, 3'h1, 13'h0000, 4'h5);
        chk("ready", rdy, 1'b1);
        n = 0;
        while (cwv !== 1'b1 && n < 40) begin
            n++;
            tick;
        end
        chk("core valid", cwv, 1'b1);
        chk("core data", cwd, {4{16'h5678, 16'h1234}});
        chk("core mask", cwm, {4{2'h2, 2'h1}});
        $display("test write done");
    endtask
    task automatic t_power;
        issue(3'h3, 3'h3, 13'h0000, 4'h2);
        issue(3'h2, 3'h1, 13'h0000, 4'h3);
        chk("one closed", act, 8'h08);
        issue(3'h2, 3'h0, 13'h0400, 4'h3);
        chk("all closed", act, 8'h00);
        issue(3'h1, 3'h0, 13'h0000, 4'h7);
        i_ctrl.desel(1'b0);
        i_ctrl.desel(1'b0);
        chk("down", pwr, 2'h1);
        i_ctrl.desel(1'b1);
        i_ctrl.desel(1'b1);
        chk("up", pwr, 2'h0);
        i_ctrl.send(3'h1, 3'h0, 13'h0000, 1'b0);
        i_ctrl.desel(1'b0);
        i_ctrl.desel(1'b0);
        chk("self", sr, 1'b1);
        chk("self state", pwr, 2'h2);
        i_ctrl.desel(1'b1);
        i_ctrl.desel(1'b1);
        chk("self exit", sr, 1'b0);
        chk("awake", pwr, 2'h0);
        $display("test power done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        close_out;
    end
    initial begin
        reset_n = 1'b0;
        otf = 1'b0;
        fix = 1'b0;
        {wdr, wdf, mkr, mkf} = 36'h1234_5678_6;
        for (int k = 0; k < 8; k++) crd[16*k +: 16] = bt(k);
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_init;
        t_read;
        t_chop;
        t_write;
        t_power;
        close_out;
    end
endmodule // ddr3_sdram_command_decoder_tb
`default_nettype wire
